// file: hdl/ests_pkg.sv
/*
  constants, state codes and input slot positions for the external test start/stop control.
  assumes a single 250 MHz core clock; every figure used by the design lives here.
*/
package ests_pkg;

  // clock period of core_clk
  localparam int unsigned CLK_PERIOD_NS = 4;

  // least time an external start/stop/loop level must stand before it counts
  localparam int unsigned QUAL_TIME_NS = 1000000;
  // least time rounds up to whole cycles
  localparam int unsigned QUAL_CYCLES_DEF = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // verdict pulse length when pulse shortening is on (plain default, longest time rounds down)
  localparam int unsigned PULSE_TIME_NS = 100000;
  localparam int unsigned PULSE_CYCLES_DEF = PULSE_TIME_NS / CLK_PERIOD_NS;

  // width of the qualify and pulse counters, wide enough for both defaults
  localparam int unsigned CNT_W = 18;

  // start source selection codes
  localparam logic [1:0] SRC_PANEL = 2'h0;
  localparam logic [1:0] SRC_HAND = 2'h1;
  localparam logic [1:0] SRC_PORT = 2'h2;

  // positions of the qualified inputs in the input vector
  localparam int unsigned IN_PANEL_LAUNCH = 0;
  localparam int unsigned IN_PANEL_HALT = 1;
  localparam int unsigned IN_HAND_LAUNCH = 2;
  localparam int unsigned IN_HAND_HALT = 3;
  localparam int unsigned IN_PORT_LAUNCH = 4;
  localparam int unsigned IN_PORT_HALT = 5;
  localparam int unsigned IN_LOOP = 6;
  localparam int unsigned NUM_IN = 7;

  // verdict output reset value and the loop drive level held after reset
  localparam logic VERDICT_IDLE = 1'h1;
  localparam logic LOOP_DRIVE_LEVEL = 1'h1;

  // operating state, one-hot
  typedef enum logic [2:0] {
    ESTS_IDLE = 3'h1,
    ESTS_READY = 3'h2,
    ESTS_TEST = 3'h4
  } ests_state_t;

endpackage : ests_pkg

// file: hdl/ests_qual.sv
/*
  one external input qualifier: three-flop synchroniser followed by a stability filter.
  assumes the pin is asynchronous to core_clk and already inverted to active high.
*/
`timescale 1ns/1ns
module ests_qual #(
  parameter int unsigned QUAL_CYCLES = ests_pkg::QUAL_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // raw level from the pin
  input wire logic pin,
  // qualified level and its assert pulse
  output logic level,
  output logic rise
);
  import ests_pkg::*;

  logic s1; // first flop, read only by s2
  logic s2; // second flop
  logic s3; // third flop
  logic [CNT_W-1:0] cnt; // cycles the new level has stood
  wire agree = (s2 == s3); // a change counts once the last two flops agree
  wire differs = agree && (s3 != level); // a new, settled level is pending
  wire done = (cnt == CNT_W'(QUAL_CYCLES - 1)); // level has stood long enough

  // synchroniser chain
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // stability filter: any glitch restarts the count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt <= '0;
      level <= 1'h0;
      rise <= 1'h0;
    end else begin
      rise <= differs && done && s3;
      if (!differs) begin
        cnt <= '0;
      end else if (done) begin
        cnt <= '0;
        level <= s3;
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // a new level is accepted only after the full stand time
  a_qual_full_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(level) |-> $past(cnt) == CNT_W'(QUAL_CYCLES - 1) && $past(differs))
    else $error("qualified level changed before its stand time");

endmodule : ests_qual

// file: hdl/ests_ctrl.sv
/*
  external test start/stop control: start source selection, halt/ready/launch sequencing,
  safety interlock and the test, pass and fail status outputs.
  assumes the measurement core reports one judgment pulse per test on the same clock,
  and that panel keys, hand controller and signal port inputs arrive asynchronously.
*/
`timescale 1ns/1ns
module ests_ctrl #(
  parameter int unsigned QUAL_CYCLES = ests_pkg::QUAL_CYCLES_DEF,
  parameter int unsigned PULSE_CYCLES = ests_pkg::PULSE_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // settings
  input wire logic [1:0] start_src,
  input wire logic interlock_en,
  input wire logic verdict_pulse_en,
  // front panel keys, active high
  input wire logic panel_launch,
  input wire logic panel_halt,
  // hand controller terminal, active high after the input stage
  input wire logic hand_ctl_launch_in,
  input wire logic hand_ctl_halt_in,
  // signal port inputs, low while shorted to the input common
  input wire logic port_launch_n,
  input wire logic port_halt_n,
  // safety loop: a is driven out, b returns it when the loop is closed
  output logic safety_loop_a,
  input wire logic safety_loop_b,
  // judgment from the measurement core, same clock
  input wire logic judge_valid,
  input wire logic judge_pass,
  // status outputs
  output logic test_active,
  output logic fail_out_n,
  output logic pass_out_n,
  output logic interlock_open,
  output logic test_begin,
  output logic test_abort
);
  import ests_pkg::*;

  ests_state_t st; // operating state
  ests_state_t next_st; // state for the next cycle
  logic [CNT_W-1:0] pulse_cnt; // remaining verdict pulse cycles
  wire [NUM_IN-1:0] raw_in; // inputs, all active high
  wire [NUM_IN-1:0] lvl; // qualified levels
  wire [NUM_IN-1:0] rise; // qualified assert pulses

  // gather the pins; port lines are active low, so invert before the synchroniser
  assign raw_in[IN_PANEL_LAUNCH] = panel_launch;
  assign raw_in[IN_PANEL_HALT] = panel_halt;
  assign raw_in[IN_HAND_LAUNCH] = hand_ctl_launch_in;
  assign raw_in[IN_HAND_HALT] = hand_ctl_halt_in;
  assign raw_in[IN_PORT_LAUNCH] = ~port_launch_n;
  assign raw_in[IN_PORT_HALT] = ~port_halt_n;
  assign raw_in[IN_LOOP] = safety_loop_b;

  // one qualifier per input; nothing below sees a raw pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_qual
      ests_qual #(.QUAL_CYCLES(QUAL_CYCLES)) u_qual (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(raw_in[gi]),
        .level(lvl[gi]),
        .rise(rise[gi])
      );
    end
  endgenerate

  // source decode
  wire sel_hand = (start_src == SRC_HAND);
  wire sel_port = (start_src == SRC_PORT);
  wire sel_panel = !sel_hand && !sel_port; // unknown codes fall back to the panel

  // launch comes only from the selected source
  wire launch_req = (sel_panel && rise[IN_PANEL_LAUNCH])
    || (sel_hand && rise[IN_HAND_LAUNCH])
    || (sel_port && rise[IN_PORT_LAUNCH]);

  // panel halt is honoured whatever the source others only when selected
  wire halt_req = rise[IN_PANEL_HALT]
    || (sel_hand && rise[IN_HAND_HALT])
    || (sel_port && rise[IN_PORT_HALT]);

  // interlock gate; with the option off the loop is ignored
  wire loop_ok = !interlock_en || lvl[IN_LOOP];

  // a start may be taken only from ready and never alongside a halt
  wire start_try = (st == ESTS_READY) && launch_req && !halt_req;
  wire start_ok = start_try && loop_ok;
  wire start_refused = start_try && !loop_ok;

  // a judgment closes the running test unless a halt wins in the same cycle
  wire judged = (st == ESTS_TEST) && judge_valid && !halt_req;
  wire aborted = (st == ESTS_TEST) && halt_req;

  // state transitions
  always_comb begin
    next_st = st;
    case (st)
      ESTS_IDLE: begin
        if (halt_req) begin
          next_st = ESTS_READY;
        end
      end
      ESTS_READY: begin
        if (start_ok) begin
          next_st = ESTS_TEST;
        end
      end
      ESTS_TEST: begin
        if (aborted || judged) begin
          next_st = ESTS_READY;
        end
      end
      default: begin
        next_st = ESTS_IDLE;
      end
    endcase
  end

  // state register and test strobes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= ESTS_IDLE;
      test_active <= 1'h0;
      test_begin <= 1'h0;
      test_abort <= 1'h0;
    end else begin
      st <= next_st;
      test_active <= (next_st == ESTS_TEST);
      test_begin <= start_ok;
      test_abort <= aborted;
    end
  end

  // interlock flag: raised by a refused start, dropped by the next accepted start or halt
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      interlock_open <= 1'h0;
    end else if (start_refused) begin
      interlock_open <= 1'h1;
    end else if (start_ok || halt_req) begin
      interlock_open <= 1'h0;
    end
  end

  // loop drive stands high so a closed loop reads back high on b
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      safety_loop_a <= 1'h0;
    end else begin
      safety_loop_a <= LOOP_DRIVE_LEVEL;
    end
  end

  // verdict outputs, active low; a new start clears the last verdict
  // with pulsing on, the verdict self-clears after PULSE_CYCLES; held otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fail_out_n <= VERDICT_IDLE;
      pass_out_n <= VERDICT_IDLE;
      pulse_cnt <= '0;
    end else if (judged) begin
      fail_out_n <= judge_pass;
      pass_out_n <= !judge_pass;
      pulse_cnt <= CNT_W'(PULSE_CYCLES);
    end else if (start_ok) begin
      fail_out_n <= VERDICT_IDLE;
      pass_out_n <= VERDICT_IDLE;
      pulse_cnt <= '0;
    end else if (verdict_pulse_en && (pulse_cnt != '0)) begin
      pulse_cnt <= pulse_cnt - CNT_W'(1);
      if (pulse_cnt == CNT_W'(1)) begin
        fail_out_n <= VERDICT_IDLE;
        pass_out_n <= VERDICT_IDLE;
      end
    end else if (verdict_pulse_en) begin
      fail_out_n <= VERDICT_IDLE; // option turned on late: release at once
      pass_out_n <= VERDICT_IDLE;
    end else begin
      pulse_cnt <= '0; // pulse off: verdict held no stale count for a late turn-on
    end
  end

  a_hand_blocks_panel: assert property (@(posedge core_clk) disable iff (!rst_n)
    sel_hand && !rise[IN_HAND_LAUNCH] && st == ESTS_READY |=> !test_begin)
    else $error("start taken from a source other than the hand controller");
  a_panel_stop_always: assert property (@(posedge core_clk) disable iff (!rst_n)
    rise[IN_PANEL_HALT] && test_active |=> !test_active && test_abort)
    else $error("panel stop did not end the test");
  a_port_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sel_port && st == ESTS_IDLE && !rise[IN_PANEL_HALT] && !(sel_hand && rise[IN_HAND_HALT])
    |=> st == ESTS_IDLE)
    else $error("idle left without a halt from an enabled source");
  a_port_halt_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
    sel_port && rise[IN_PORT_HALT] |=> st == ESTS_READY && !test_active)
    else $error("port halt did not give ready");
  a_start_needs_loop: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(test_active) |-> $past(!interlock_en || lvl[IN_LOOP]) && test_begin)
    else $error("test started with the interlock loop open");
  a_refuse_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_refused |=> interlock_open && !test_active && !test_begin)
    else $error("open loop start not refused and flagged");
  a_judge_verdict: assert property (@(posedge core_clk) disable iff (!rst_n)
    judged |=> !test_active && (fail_out_n == $past(judge_pass))
    && (pass_out_n == !$past(judge_pass)))
    else $error("judgment not reflected on verdict outputs");
  a_verdict_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    !verdict_pulse_en && !fail_out_n && !start_ok && !judged |=> !fail_out_n)
    else $error("fail verdict dropped while pulsing is off");
  a_stop_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    st == ESTS_READY && launch_req && halt_req |=> !test_active && !test_begin)
    else $error("start taken alongside a stop");

endmodule : ests_ctrl

// file: test/ests_far_side.sv
/*
  far side model: hand controller, signal port automation and the safety loop key.
  assumes the bench calls its tasks at falling edges of core_clk.
*/
`timescale 1ns/1ns
module ests_far_side (
  // clock
  input wire logic core_clk,
  // loop drive from the device
  input wire logic safety_loop_a,
  // hand controller, active high
  output logic hand_ctl_launch_in,
  output logic hand_ctl_halt_in,
  // signal port, low while shorted to common
  output logic port_launch_n,
  output logic port_halt_n,
  // loop return
  output logic safety_loop_b
);
  logic loop_closed; // key inserted or pins shorted
  // idle: hand lines low, port lines open and so pulled high
  initial begin
    hand_ctl_launch_in = 1'h0;
    hand_ctl_halt_in = 1'h0;
    port_launch_n = 1'h1;
    port_halt_n = 1'h1;
    loop_closed = 1'h1;
  end
  // open loop reads low through the receiver pull-down; the key starts inserted
  assign safety_loop_b = loop_closed & safety_loop_a;
  // one press held for hold cycles; caller keeps hold above the qualify time
  task automatic press(input logic [3:0] req, input int hold);
    hand_ctl_launch_in = req[0];
    hand_ctl_halt_in = req[1];
    port_launch_n = ~req[2];
    port_halt_n = ~req[3];
    repeat (hold) @(negedge core_clk);
    hand_ctl_launch_in = 1'h0;
    hand_ctl_halt_in = 1'h0;
    port_launch_n = 1'h1;
    port_halt_n = 1'h1;
  endtask : press
  // insert or pull the loop key
  task automatic set_loop(input logic closed);
    loop_closed = closed;
  endtask : set_loop
endmodule : ests_far_side

// file: test/ests_ctrl_tb.sv
/*
  self-checking bench for ests_ctrl with a behavioural model of the sequencing.
  assumes shortened qualify (8) and pulse (5) counts; inputs change at falling edges.
*/
`timescale 1ns/1ns
module ests_ctrl_tb;
  import ests_pkg::*;
  localparam int unsigned Q = 8; // shortened qualify count
  localparam int unsigned P = 5; // shortened verdict pulse
  logic core_clk, rst_n, interlock_en, verdict_pulse_en, panel_launch, panel_halt;
  logic judge_valid, judge_pass, jp;
  logic [1:0] start_src;
  logic hand_l, hand_h, port_l_n, port_h_n, loop_a, loop_b;
  logic test_active, fail_out_n, pass_out_n, interlock_open, test_begin, test_abort;
  int n_mismatch, compares, cycles, n_begin, n_abort, seed;
  int st, m_begin, m_abort; // model: state 0 idle 1 ready 2 test
  logic m_iop, m_pass_n, m_fail_n, m_loop; // model outputs and loop key
  ests_ctrl #(.QUAL_CYCLES(Q), .PULSE_CYCLES(P)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .start_src(start_src), .interlock_en(interlock_en), .verdict_pulse_en(verdict_pulse_en),
    .panel_launch(panel_launch), .panel_halt(panel_halt), .hand_ctl_launch_in(hand_l),
    .hand_ctl_halt_in(hand_h), .port_launch_n(port_l_n), .port_halt_n(port_h_n),
    .safety_loop_a(loop_a), .safety_loop_b(loop_b), .judge_valid(judge_valid),
    .judge_pass(judge_pass), .test_active(test_active), .fail_out_n(fail_out_n),
    .pass_out_n(pass_out_n), .interlock_open(interlock_open), .test_begin(test_begin),
    .test_abort(test_abort));
  ests_far_side far_u (.core_clk(core_clk), .safety_loop_a(loop_a),
    .hand_ctl_launch_in(hand_l), .hand_ctl_halt_in(hand_h), .port_launch_n(port_l_n),
    .port_halt_n(port_h_n), .safety_loop_b(loop_b));
  // 250 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  // pulse counters and hang guard; a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (test_begin === 1'h1) n_begin++;
    if (test_abort === 1'h1) n_abort++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  // compare every status output and pulse count with the model
  task automatic check_all;
    chk("test_active", st == 2, test_active);
    chk("interlock_open", m_iop, interlock_open);
    chk("pass_out_n", m_pass_n, pass_out_n);
    chk("fail_out_n", m_fail_n, fail_out_n);
    chk("begin count match", 1'h1, n_begin == m_begin);
    chk("abort count match", 1'h1, n_abort == m_abort);
  endtask : check_all
  // m: 0 panel launch, 1 panel halt, 2 hand launch, 3 hand halt, 4 port launch, 5 port halt
  task automatic press(input logic [5:0] m);
    logic halt_ok, launch_ok;
    int hold;
    hold = Q + 2 + ($unsigned($random(seed)) % 4);
    @(negedge core_clk);
    panel_launch = m[0];
    panel_halt = m[1];
    far_u.press(m[5:2], hold);
    panel_launch = 1'h0;
    panel_halt = 1'h0;
    repeat (Q + 8) @(negedge core_clk);
    halt_ok = m[1] | (m[3] & start_src == SRC_HAND) | (m[5] & start_src == SRC_PORT);
    launch_ok = (m[0] & start_src != SRC_HAND & start_src != SRC_PORT) // code 3 acts as panel
      | (m[2] & start_src == SRC_HAND)
      | (m[4] & start_src == SRC_PORT);
    // halt beats a launch in the same press
    if (halt_ok) begin
      if (st == 2) m_abort++;
      st = 1;
      m_iop = 1'h0;
    end else if (launch_ok && st == 1) begin
      if (interlock_en && !m_loop) m_iop = 1'h1;
      else begin
        st = 2;
        m_begin++;
        m_iop = 1'h0;
        m_pass_n = 1'h1;
        m_fail_n = 1'h1;
      end
    end
    check_all();
  endtask : press
  // one judgment pulse; with pulsing on the verdict must fall back after P+1 edges
  task automatic judge(input logic pass);
    @(negedge core_clk);
    judge_valid = 1'h1;
    judge_pass = pass;
    @(negedge core_clk);
    judge_valid = 1'h0;
    repeat (2) @(negedge core_clk);
    if (st == 2) begin
      st = 1;
      m_pass_n = ~pass;
      m_fail_n = pass;
    end
    check_all();
    repeat (P + 2) @(negedge core_clk);
    if (verdict_pulse_en) begin
      m_pass_n = 1'h1;
      m_fail_n = 1'h1;
    end
    check_all();
  endtask : judge
  task automatic loop(input logic closed);
    far_u.set_loop(closed);
    m_loop = closed;
    repeat (Q + 8) @(negedge core_clk);
  endtask : loop
  initial begin
    {rst_n, interlock_en, verdict_pulse_en, panel_launch, panel_halt} = 5'h00;
    {judge_valid, judge_pass, start_src} = 4'h0;
    {n_mismatch, compares, cycles, n_begin, n_abort, st, m_begin, m_abort} = '0;
    {m_iop, m_pass_n, m_fail_n, m_loop} = 4'h7;
    seed = 24225;
    repeat (16) @(negedge core_clk);
    rst_n = 1'h1;
    repeat (2) @(negedge core_clk);
    chk("safety_loop_a", 1'h1, loop_a);
    check_all();
    press(6'h02);
    press(6'h01);
    judge(1'h0);
    press(6'h03);
    panel_launch = 1'h1; // short blip must be ignored
    repeat (Q - 2) @(negedge core_clk);
    panel_launch = 1'h0;
    repeat (Q + 8) @(negedge core_clk);
    check_all();
    press(6'h10);
    press(6'h01);
    start_src = SRC_HAND;
    press(6'h08);
    press(6'h01);
    press(6'h04);
    press(6'h02);
    press(6'h20);
    start_src = SRC_PORT;
    press(6'h20);
    press(6'h04);
    press(6'h10);
    judge(1'h1);
    press(6'h10);
    press(6'h20);
    press(6'h10);
    press(6'h02);
    interlock_en = 1'h1;
    loop(1'h0);
    press(6'h10);
    press(6'h20);
    loop(1'h1);
    press(6'h10);
    jp = 1'($random(seed));
    judge(jp);
    interlock_en = 1'h0;
    verdict_pulse_en = 1'h1;
    m_pass_n = 1'h1; // turning pulsing on releases a held verdict at once
    m_fail_n = 1'h1;
    loop(1'h0);
    check_all();
    press(6'h10);
    jp = 1'($random(seed));
    judge(jp);
    rst_n = 1'h0; // mid-run reset: back to idle with verdicts released
    repeat (4) @(negedge core_clk);
    rst_n = 1'h1;
    st = 0;
    m_iop = 1'h0;
    m_pass_n = 1'h1;
    m_fail_n = 1'h1;
    start_src = 2'h3; // unused code must behave as the panel
    repeat (2) @(negedge core_clk);
    check_all();
    press(6'h20);
    press(6'h01);
    press(6'h02);
    press(6'h01);
    start_src = SRC_PORT;
    press(6'h20);
    give_verdict();
  end
endmodule : ests_ctrl_tb
